// ---- testbench/crxf_node_model.sv ----
`timescale 1ns/100ps
module crxf_node_model
(
    input wire logic clk,
    output logic msg_valid,
    output logic msg_ext,
    output logic [10:0] msg_sid,
    output logic [17:0] msg_eid,
    output logic store_valid,
    output logic [4:0] store_buf
);
    // Idle state at time zero
    initial
    begin
        msg_valid = 1'b0;
        msg_ext = 1'b0;
        msg_sid = 11'h000;
        msg_eid = 18'h00000;
        store_valid = 1'b0;
        store_buf = 5'h00;
    end

    // One frame for a single cycle; lines scrambled after so stale ids never look valid
    task automatic send_msg(input logic ext, input logic [10:0] sid, input logic [17:0] eid);
        @(posedge clk);
        msg_valid <= 1'b1;
        msg_ext <= ext;
        msg_sid <= sid;
        msg_eid <= eid;
        @(posedge clk);
        msg_valid <= 1'b0;
        msg_ext <= ~ext;
        msg_sid <= ~sid;
        msg_eid <= ~eid;
    endtask

    // Receive engine writes one message into a buffer
    task automatic store(input logic [4:0] idx);
        @(posedge clk);
        store_valid <= 1'b1;
        store_buf <= idx;
        @(posedge clk);
        store_valid <= 1'b0;
        store_buf <= ~idx;
    endtask
endmodule

// ---- testbench/crxf_top_properties.sv ----
`timescale 1ns/100ps
module crxf_top_properties
(
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic MSG_VALID,
    input wire logic HIT_VALID,
    input wire logic STORE_VALID,
    input wire logic [4:0] STORE_BUF,
    input wire logic [31:0] FULL_FLAGS,
    input wire logic [31:0] OVF_FLAGS
);
    // Single clock domain
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);

    // Match result is a one-cycle pulse per message
    hit_follow_a: assert property (MSG_VALID |=> HIT_VALID)
        else $error("hit valid missing after message");
    hit_pulse_a: assert property (!MSG_VALID |=> !HIT_VALID)
        else $error("hit valid without message");

    // Stores set flags on the next edge
    full_set_a: assert property (STORE_VALID |=> FULL_FLAGS[$past(STORE_BUF)])
        else $error("full flag not set by store");
    ovf_set_a: assert property (STORE_VALID && FULL_FLAGS[STORE_BUF] |=> OVF_FLAGS[$past(STORE_BUF)])
        else $error("overflow flag not set on store to full buffer");

    // Software writes may only clear, so no flag rises without a store
    full_no_rise_a: assert property (!STORE_VALID |=> (FULL_FLAGS & ~$past(FULL_FLAGS)) == 32'h0000_0000)
        else $error("full flag rose without store");
    ovf_no_rise_a: assert property (!STORE_VALID |=> (OVF_FLAGS & ~$past(OVF_FLAGS)) == 32'h0000_0000)
        else $error("overflow flag rose without store");

    // Register bus answers
    rd_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
        else $error("read answer late");
    rd_reserved_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY
        && S_AXI_ARADDR inside {8'h04, 8'h0C, 8'h14} |=> S_AXI_RDATA[4] == 1'b0 && S_AXI_RDATA[2] == 1'b0)
        else $error("unimplemented mask bits read nonzero");
    rd_upper_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0000)
        else $error("upper read data nonzero");
    wr_release_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
        else $error("write response held after handshake");
endmodule

bind crxf_top crxf_top_properties u_props
(
    .MCLK(MCLK), .RST_N(RST_N), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .MSG_VALID(MSG_VALID), .HIT_VALID(HIT_VALID),
    .STORE_VALID(STORE_VALID), .STORE_BUF(STORE_BUF), .FULL_FLAGS(FULL_FLAGS), .OVF_FLAGS(OVF_FLAGS)
);

// ---- testbench/tb_crxf_top.sv ----
`timescale 1ns/100ps
module tb_crxf_top;
    logic MCLK, RST_N, AWV, WV, BR, ARV, RR, BV, AWR, WR, ARR, RV, MV, MX, SV, HV;
    logic [7:0] AWA, ARA, FH;
    logic [31:0] WD, RD, FF, OF;
    logic [3:0] WS;
    logic [1:0] BRS, RRS, wr_resp, rd_resp;
    logic [10:0] MS;
    logic [17:0] ME;
    logic [4:0] SB;
    logic [31:0] rd_data;
    int fail_count = 0, n_tests = 0, cycles = 0;

    crxf_top uut
    (
        .MCLK(MCLK), .RST_N(RST_N), .S_AXI_AWADDR(AWA), .S_AXI_AWVALID(AWV), .S_AXI_AWREADY(AWR),
        .S_AXI_WDATA(WD), .S_AXI_WSTRB(WS), .S_AXI_WVALID(WV), .S_AXI_WREADY(WR), .S_AXI_BRESP(BRS),
        .S_AXI_BVALID(BV), .S_AXI_BREADY(BR), .S_AXI_ARADDR(ARA), .S_AXI_ARVALID(ARV), .S_AXI_ARREADY(ARR),
        .S_AXI_RDATA(RD), .S_AXI_RRESP(RRS), .S_AXI_RVALID(RV), .S_AXI_RREADY(RR), .MSG_VALID(MV),
        .MSG_EXT(MX), .MSG_SID(MS), .MSG_EID(ME), .FILTER_HIT(FH), .HIT_VALID(HV), .STORE_VALID(SV),
        .STORE_BUF(SB), .FULL_FLAGS(FF), .OVF_FLAGS(OF)
    );

    crxf_node_model node
    (
        .clk(MCLK), .msg_valid(MV), .msg_ext(MX), .msg_sid(MS), .msg_eid(ME), .store_valid(SV), .store_buf(SB)
    );

    // 25 MHz system clock
    initial
    begin
        MCLK = 1'b0;
        forever #20 MCLK = ~MCLK;
    end

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Write with both address and data offered; each dropped when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic done;
        @(posedge MCLK);
        AWA <= a;
        WD <= d;
        AWV <= 1'b1;
        WV <= 1'b1;
        BR <= 1'b1;
        done = 1'b0;
        while (!done)
        begin
            @(posedge MCLK);
            if (AWV && AWR)
                AWV <= 1'b0;
            if (WV && WR)
                WV <= 1'b0;
            if (BV)
            begin
                wr_resp = BRS;
                BR <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    task automatic axi_rd(input logic [7:0] a);
        logic done;
        @(posedge MCLK);
        ARA <= a;
        ARV <= 1'b1;
        RR <= 1'b1;
        done = 1'b0;
        while (!done)
        begin
            @(posedge MCLK);
            if (ARV && ARR)
                ARV <= 1'b0;
            if (RV)
            begin
                rd_data = RD;
                rd_resp = RRS;
                RR <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        axi_rd(a);
        check($sformatf("reg %h", a), rd_data, exp);
    endtask

    // Send one identifier and compare the hit vector of filters 15..8
    task automatic msg_chk(input logic ext, input logic [10:0] sid, input logic [17:0] eid, input logic [7:0] exp);
        node.send_msg(ext, sid, eid);
        @(negedge MCLK);
        check("hit_valid", {31'h0, HV}, 32'h1);
        check("filter_hit", {24'h0, FH}, {24'h0, exp});
    endtask

    // Hang guard
    always @(posedge MCLK)
    begin
        cycles <= cycles + 1;
        if (cycles == 4000)
        begin
            fail_count++;
            final_report();
        end
    end

    // Main sequence
    initial
    begin
        {RST_N, AWV, WV, BR, ARV, RR} = 6'h00;
        AWA = 8'h00;
        ARA = 8'h00;
        WD = 32'h0;
        WS = 4'hF;
        repeat (5) @(posedge MCLK);
        RST_N <= 1'b1;
        for (int i = 0; i < 5; i++)
            rd_chk((i == 0) ? 8'h00 : 8'h18 + 8'(i * 4), 32'h0);
        axi_wr(8'h3C, 32'hFFFF);
        check("bresp", {30'h0, wr_resp}, {30'h0, crxf_pkg::RESP_SLVERR});
        axi_rd(8'h3C);
        check("rresp", {30'h0, rd_resp}, {30'h0, crxf_pkg::RESP_SLVERR});
        $display("test reset done");
        for (int m = 0; m < 3; m++)
        begin
            axi_wr(8'h04 + 8'(m * 8), 32'hFFFF);
            axi_wr(8'h08 + 8'(m * 8), 32'h1230 + m);
            rd_chk(8'h04 + 8'(m * 8), 32'hFFEB);
            rd_chk(8'h08 + 8'(m * 8), 32'h1230 + m);
        end
        $display("test masks done");
        // Filters 15..12 use 0,1,2,none and 11..8 use none,2,1,0
        axi_wr(8'h00, 32'h1BE4);
        rd_chk(8'h00, 32'h1BE4);
        axi_wr(8'h04, 32'h0);
        axi_wr(8'h08, 32'h0);
        axi_wr(8'h0C, 32'hFFE3);
        axi_wr(8'h10, 32'hFFFF);
        axi_wr(8'h14, 32'h0008);
        axi_wr(8'h18, 32'h0);
        msg_chk(1'b0, 11'h5A5, 18'h0, 8'hA5);
        msg_chk(1'b1, 11'h0, 18'h00001, 8'h81);
        msg_chk(1'b1, 11'h0, 18'h20000, 8'h81);
        msg_chk(1'b0, 11'h0, 18'h0, 8'hFF);
        axi_wr(8'h48, 32'hB4A0);
        axi_wr(8'h50, 32'h0008);
        msg_chk(1'b0, 11'h5A5, 18'h0, 8'hA3);
        msg_chk(1'b1, 11'h0, 18'h00001, 8'h85);
        $display("test match done");
        node.store(5'd3);
        @(negedge MCLK);
        check("full", FF, 32'h8);
        node.store(5'd3);
        node.store(5'd31);
        rd_chk(8'h24, 32'h0008);
        rd_chk(8'h20, 32'h8000);
        axi_wr(8'h1C, 32'hFFFF);
        rd_chk(8'h1C, 32'h0008);
        axi_wr(8'h1C, 32'h0);
        axi_wr(8'h20, 32'h7FFF);
        axi_wr(8'h24, 32'h0);
        check("full", FF, 32'h0);
        check("ovf", OF, 32'h0);
        node.store(5'd3);
        @(negedge MCLK);
        check("ovf", OF, 32'h0);
        // A store in the cycle of a clear still sets
        fork
            axi_wr(8'h1C, 32'h0);
            @(posedge MCLK) node.store(5'd5);
        join
        check("full", FF, 32'h20);
        $display("test flags done");
        final_report();
    end
endmodule

// ---- verilog/crxf_flags.sv ----
`timescale 1ns/100ps
module crxf_flags
#(
    parameter int NUM_BUF = crxf_pkg::NUM_BUF,
    parameter int IDX_W = crxf_pkg::BUF_IDX_W
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic store_valid,
    input wire logic [IDX_W-1:0] store_idx,
    input wire logic [NUM_BUF-1:0] clr_full,
    input wire logic [NUM_BUF-1:0] clr_ovf,
    output logic [NUM_BUF-1:0] full_q,
    output logic [NUM_BUF-1:0] ovf_q
);
    logic [NUM_BUF-1:0] full_d;
    logic [NUM_BUF-1:0] ovf_d;
    logic [NUM_BUF-1:0] hit_buf;

    // A store into a full buffer marks overflow and keeps full set; set beats clear
    always_comb
    begin
        hit_buf = '0;
        if (store_valid)
        begin
            hit_buf[store_idx] = 1'b1;
        end
        full_d = (full_q & ~clr_full) | hit_buf;
        ovf_d = (ovf_q & ~clr_ovf) | (hit_buf & full_q);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            full_q <= '0;
            ovf_q <= '0;
        end
        else
        begin
            full_q <= full_d;
            ovf_q <= ovf_d;
        end
    end

endmodule

// ---- verilog/crxf_match.sv ----
`timescale 1ns/100ps
module crxf_match
(
    input wire logic [1:0] filter_mask_source_sel,
    input wire crxf_pkg::crxf_mask_set_t masks,
    input wire crxf_pkg::crxf_filt_t filt,
    input wire crxf_pkg::crxf_msg_t msg,
    output logic hit
);
    crxf_pkg::crxf_mask_t mask;
    logic sid_ok;
    logic eid_ok;
    logic type_ok;

    // Pick the mask; no mask compares every bit and honours the format bit
    always_comb
    begin
        unique case (filter_mask_source_sel)
            crxf_pkg::SEL_MASK0: mask = masks[0];
            crxf_pkg::SEL_MASK1: mask = masks[1];
            crxf_pkg::SEL_MASK2: mask = masks[2];
            crxf_pkg::SEL_NONE: mask = '1;
        endcase
    end

    // A one in the mask compares the bit, a zero ignores it
    always_comb
    begin
        sid_ok = ((msg.sid ^ filt.sid) & mask.sid) == 11'h000;
        eid_ok = ((msg.eid ^ filt.eid) & mask.eid) == 18'h00000;
        type_ok = !mask.id_type_match_enable
            || (msg.ext == filt.filter_extended_format_sel);
        // Standard frames carry no extended bits, so the EID is not compared
        hit = sid_ok && (eid_ok || !msg.ext) && type_ok;
    end

endmodule

// ---- verilog/crxf_pkg.sv ----
package crxf_pkg;

    // Sizes of the receive filter block
    localparam int REG_W = 16;
    localparam int NUM_FILT = 8;
    localparam int NUM_MASK = 3;
    localparam int NUM_BUF = 32;
    localparam int BUF_IDX_W = 5;
    localparam int SEL_W = 2;
    localparam int ADDR_W = 8;

    // Register byte addresses on the AXI4-Lite slave
    localparam logic [7:0] OFF_MASK_SEL = 8'h00;
    localparam logic [7:0] OFF_MSK_STD_BASE = 8'h04;
    localparam logic [7:0] OFF_MSK_EXT_BASE = 8'h08;
    localparam logic [7:0] MSK_STRIDE = 8'h08;
    localparam logic [7:0] OFF_FULL_LO = 8'h1C;
    localparam logic [7:0] OFF_FULL_HI = 8'h20;
    localparam logic [7:0] OFF_OVF_LO = 8'h24;
    localparam logic [7:0] OFF_OVF_HI = 8'h28;
    localparam logic [7:0] OFF_FLT_STD_BASE = 8'h40;
    localparam logic [7:0] OFF_FLT_EXT_BASE = 8'h44;
    localparam logic [7:0] FLT_STRIDE = 8'h08;

    // Field positions in the standard words of masks and filters
    localparam int SID_MSB = 15;
    localparam int SID_LSB = 5;
    localparam int TYPE_BIT = 3;
    localparam int EIDH_MSB = 1;
    localparam logic [15:0] STD_IMPL_BITS = 16'hFFEB;

    // Mask source selector codes
    localparam logic [1:0] SEL_MASK0 = 2'h0;
    localparam logic [1:0] SEL_MASK1 = 2'h1;
    localparam logic [1:0] SEL_MASK2 = 2'h2;
    localparam logic [1:0] SEL_NONE = 2'h3;

    // Reset values
    localparam logic [15:0] MASK_SEL_RST = 16'h0000;
    localparam logic [15:0] MSK_RST = 16'h0000;
    localparam logic [15:0] FLT_RST = 16'h0000;
    localparam logic [31:0] FLAG_RST = 32'h0000_0000;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Received identifier as it reaches the filters
    typedef struct packed {
        logic ext;
        logic [10:0] sid;
        logic [17:0] eid;
    } crxf_msg_t;

    // One acceptance mask set
    typedef struct packed {
        logic [10:0] sid;
        logic id_type_match_enable;
        logic [17:0] eid;
    } crxf_mask_t;

    typedef crxf_mask_t [NUM_MASK-1:0] crxf_mask_set_t;

    // One acceptance filter
    typedef struct packed {
        logic [10:0] sid;
        logic filter_extended_format_sel;
        logic [17:0] eid;
    } crxf_filt_t;

endpackage

// ---- verilog/crxf_top.sv ----
`timescale 1ns/100ps
// Operation
// - Two-bit selector picks mask 0-2 or none
// - Filter 15 at bits 15-14, filter 8 at 1-0
// - Three mask sets, standard and extended word
// - Standard word bits 15-5 mask SID bits
// - EID 17:16 from standard word, 15:0 extended
// - Type bit set: frame format must match filter
// - Type bit clear: either format may match
// - Bits 4 and 2 read as zero
// - Full flag per buffer, set on store
// - Store into full buffer sets overflow flag
// - Software clears flags by writing zero only
// - Filter format bit picks extended or standard frames
// - Filter ID bit gives required message bit value
module crxf_top
(
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic MSG_VALID,
    input wire logic MSG_EXT,
    input wire logic [10:0] MSG_SID,
    input wire logic [17:0] MSG_EID,
    output logic [7:0] FILTER_HIT,
    output logic HIT_VALID,
    input wire logic STORE_VALID,
    input wire logic [4:0] STORE_BUF,
    output logic [31:0] FULL_FLAGS,
    output logic [31:0] OVF_FLAGS
);
    localparam int NF = crxf_pkg::NUM_FILT;
    localparam int NM = crxf_pkg::NUM_MASK;

    // Bus handshake state
    logic awready_q, awready_d;
    logic wready_q, wready_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic arready_q, arready_d;
    logic rvalid_q, rvalid_d;
    logic [1:0] rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic [7:0] waddr_q, waddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;

    // Configuration registers
    logic [15:0] sel_q, sel_d;
    logic [15:0] msk_std_q [NM], msk_std_d [NM];
    logic [15:0] msk_ext_q [NM], msk_ext_d [NM];
    logic [15:0] flt_std_q [NF], flt_std_d [NF];
    logic [15:0] flt_ext_q [NF], flt_ext_d [NF];

    // Flag clear requests and flag state
    logic [31:0] clr_full;
    logic [31:0] clr_ovf;
    logic [31:0] full_flags;
    logic [31:0] ovf_flags;
    logic do_write;
    logic w_hit;

    // Filter path
    crxf_pkg::crxf_msg_t msg;
    crxf_pkg::crxf_mask_set_t masks;
    crxf_pkg::crxf_filt_t filt [NF];
    logic [NF-1:0] hit_now;
    logic [NF-1:0] hit_q, hit_d;
    logic hit_valid_q, hit_valid_d;

    // Merge the two low byte lanes of a write into a 16-bit register
    function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] data,
                                               input logic [3:0] strb);
        logic [15:0] res;
        res = old;
        if (strb[0])
        begin
            res[7:0] = data[7:0];
        end
        if (strb[1])
        begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction

    // Zeros written in enabled lanes become clear requests; ones do nothing
    function automatic logic [15:0] zero_clear(input logic [31:0] data, input logic [3:0] strb);
        logic [15:0] res;
        res = 16'h0000;
        if (strb[0])
        begin
            res[7:0] = ~data[7:0];
        end
        if (strb[1])
        begin
            res[15:8] = ~data[15:8];
        end
        return res;
    endfunction

    // Address and data are taken in either order; write fires once both are held
    always_comb
    begin
        awready_d = awready_q;
        wready_d = wready_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        waddr_d = waddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        do_write = !awready_q && !wready_q && !bvalid_q;
        if (S_AXI_AWVALID && awready_q)
        begin
            awready_d = 1'b0;
            waddr_d = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && wready_q)
        begin
            wready_d = 1'b0;
            wdata_d = S_AXI_WDATA;
            wstrb_d = S_AXI_WSTRB;
        end
        if (do_write)
        begin
            bvalid_d = 1'b1;
            bresp_d = w_hit ? crxf_pkg::RESP_OKAY : crxf_pkg::RESP_SLVERR;
        end
        if (bvalid_q && S_AXI_BREADY)
        begin
            bvalid_d = 1'b0;
            awready_d = 1'b1;
            wready_d = 1'b1;
        end
    end

    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= crxf_pkg::RESP_OKAY;
            waddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end
        else
        begin
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            waddr_q <= waddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
        end
    end

    // Register writes; unmapped addresses change nothing and answer SLVERR
    always_comb
    begin
        sel_d = sel_q;
        msk_std_d = msk_std_q;
        msk_ext_d = msk_ext_q;
        flt_std_d = flt_std_q;
        flt_ext_d = flt_ext_q;
        clr_full = 32'h0000_0000;
        clr_ovf = 32'h0000_0000;
        w_hit = 1'b0;
        if (waddr_q == crxf_pkg::OFF_MASK_SEL)
        begin
            w_hit = 1'b1;
            if (do_write)
            begin
                sel_d = lane_merge(sel_q, wdata_q, wstrb_q);
            end
        end
        if (waddr_q == crxf_pkg::OFF_FULL_LO || waddr_q == crxf_pkg::OFF_FULL_HI
            || waddr_q == crxf_pkg::OFF_OVF_LO || waddr_q == crxf_pkg::OFF_OVF_HI)
        begin
            w_hit = 1'b1;
        end
        if (do_write)
        begin
            unique case (waddr_q)
                crxf_pkg::OFF_FULL_LO: clr_full[15:0] = zero_clear(wdata_q, wstrb_q);
                crxf_pkg::OFF_FULL_HI: clr_full[31:16] = zero_clear(wdata_q, wstrb_q);
                crxf_pkg::OFF_OVF_LO: clr_ovf[15:0] = zero_clear(wdata_q, wstrb_q);
                crxf_pkg::OFF_OVF_HI: clr_ovf[31:16] = zero_clear(wdata_q, wstrb_q);
                default: ;
            endcase
        end
        for (int m = 0; m < NM; m++)
        begin
            if (waddr_q == crxf_pkg::OFF_MSK_STD_BASE + 8'(m) * crxf_pkg::MSK_STRIDE)
            begin
                w_hit = 1'b1;
                if (do_write)
                begin
                    // Unimplemented bits are never stored, so they read back zero
                    msk_std_d[m] = lane_merge(msk_std_q[m], wdata_q, wstrb_q) & crxf_pkg::STD_IMPL_BITS;
                end
            end
            if (waddr_q == crxf_pkg::OFF_MSK_EXT_BASE + 8'(m) * crxf_pkg::MSK_STRIDE)
            begin
                w_hit = 1'b1;
                if (do_write)
                begin
                    msk_ext_d[m] = lane_merge(msk_ext_q[m], wdata_q, wstrb_q);
                end
            end
        end
        for (int f = 0; f < NF; f++)
        begin
            if (waddr_q == crxf_pkg::OFF_FLT_STD_BASE + 8'(f) * crxf_pkg::FLT_STRIDE)
            begin
                w_hit = 1'b1;
                if (do_write)
                begin
                    flt_std_d[f] = lane_merge(flt_std_q[f], wdata_q, wstrb_q) & crxf_pkg::STD_IMPL_BITS;
                end
            end
            if (waddr_q == crxf_pkg::OFF_FLT_EXT_BASE + 8'(f) * crxf_pkg::FLT_STRIDE)
            begin
                w_hit = 1'b1;
                if (do_write)
                begin
                    flt_ext_d[f] = lane_merge(flt_ext_q[f], wdata_q, wstrb_q);
                end
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            sel_q <= crxf_pkg::MASK_SEL_RST;
            for (int m = 0; m < NM; m++)
            begin
                msk_std_q[m] <= crxf_pkg::MSK_RST;
                msk_ext_q[m] <= crxf_pkg::MSK_RST;
            end
            for (int f = 0; f < NF; f++)
            begin
                flt_std_q[f] <= crxf_pkg::FLT_RST;
                flt_ext_q[f] <= crxf_pkg::FLT_RST;
            end
        end
        else
        begin
            sel_q <= sel_d;
            msk_std_q <= msk_std_d;
            msk_ext_q <= msk_ext_d;
            flt_std_q <= flt_std_d;
            flt_ext_q <= flt_ext_d;
        end
    end

    // Read path: data registered, answer one cycle after the address is taken
    always_comb
    begin
        arready_d = arready_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (S_AXI_ARVALID && arready_q)
        begin
            arready_d = 1'b0;
            rvalid_d = 1'b1;
            rresp_d = crxf_pkg::RESP_OKAY;
            rdata_d = 32'h0000_0000;
            unique case (S_AXI_ARADDR)
                crxf_pkg::OFF_MASK_SEL: rdata_d[15:0] = sel_q;
                crxf_pkg::OFF_FULL_LO: rdata_d[15:0] = full_flags[15:0];
                crxf_pkg::OFF_FULL_HI: rdata_d[15:0] = full_flags[31:16];
                crxf_pkg::OFF_OVF_LO: rdata_d[15:0] = ovf_flags[15:0];
                crxf_pkg::OFF_OVF_HI: rdata_d[15:0] = ovf_flags[31:16];
                default: rresp_d = crxf_pkg::RESP_SLVERR;
            endcase
            for (int m = 0; m < NM; m++)
            begin
                if (S_AXI_ARADDR == crxf_pkg::OFF_MSK_STD_BASE + 8'(m) * crxf_pkg::MSK_STRIDE)
                begin
                    rdata_d[15:0] = msk_std_q[m];
                    rresp_d = crxf_pkg::RESP_OKAY;
                end
                if (S_AXI_ARADDR == crxf_pkg::OFF_MSK_EXT_BASE + 8'(m) * crxf_pkg::MSK_STRIDE)
                begin
                    rdata_d[15:0] = msk_ext_q[m];
                    rresp_d = crxf_pkg::RESP_OKAY;
                end
            end
            for (int f = 0; f < NF; f++)
            begin
                if (S_AXI_ARADDR == crxf_pkg::OFF_FLT_STD_BASE + 8'(f) * crxf_pkg::FLT_STRIDE)
                begin
                    rdata_d[15:0] = flt_std_q[f];
                    rresp_d = crxf_pkg::RESP_OKAY;
                end
                if (S_AXI_ARADDR == crxf_pkg::OFF_FLT_EXT_BASE + 8'(f) * crxf_pkg::FLT_STRIDE)
                begin
                    rdata_d[15:0] = flt_ext_q[f];
                    rresp_d = crxf_pkg::RESP_OKAY;
                end
            end
        end
        if (rvalid_q && S_AXI_RREADY)
        begin
            rvalid_d = 1'b0;
            arready_d = 1'b1;
        end
    end

    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rresp_q <= crxf_pkg::RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    // Unpack register words into mask and filter fields
    always_comb
    begin
        msg.ext = MSG_EXT;
        msg.sid = MSG_SID;
        msg.eid = MSG_EID;
        for (int m = 0; m < NM; m++)
        begin
            masks[m].sid = msk_std_q[m][crxf_pkg::SID_MSB:crxf_pkg::SID_LSB];
            masks[m].id_type_match_enable = msk_std_q[m][crxf_pkg::TYPE_BIT];
            masks[m].eid = {msk_std_q[m][crxf_pkg::EIDH_MSB:0], msk_ext_q[m]};
        end
        for (int f = 0; f < NF; f++)
        begin
            filt[f].sid = flt_std_q[f][crxf_pkg::SID_MSB:crxf_pkg::SID_LSB];
            filt[f].filter_extended_format_sel = flt_std_q[f][crxf_pkg::TYPE_BIT];
            filt[f].eid = {flt_std_q[f][crxf_pkg::EIDH_MSB:0], flt_ext_q[f]};
        end
    end

    // One comparator per upper filter; filter 8+k uses selector bits 2k+1:2k
    for (genvar k = 0; k < NF; k++)
    begin : g_filt
        crxf_match u_match
        (
            .filter_mask_source_sel(sel_q[2*k +: 2]),
            .masks(masks),
            .filt(filt[k]),
            .msg(msg),
            .hit(hit_now[k])
        );
    end

    // Hits are latched per message so the outputs stay flop-driven
    always_comb
    begin
        hit_d = hit_q;
        hit_valid_d = MSG_VALID;
        if (MSG_VALID)
        begin
            hit_d = hit_now;
        end
    end

    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            hit_q <= '0;
            hit_valid_q <= 1'b0;
        end
        else
        begin
            hit_q <= hit_d;
            hit_valid_q <= hit_valid_d;
        end
    end

    // Full and overflow flags; a store in the clear cycle still sets
    crxf_flags u_flags
    (
        .clk(MCLK),
        .rst_n(RST_N),
        .store_valid(STORE_VALID),
        .store_idx(STORE_BUF),
        .clr_full(clr_full),
        .clr_ovf(clr_ovf),
        .full_q(full_flags),
        .ovf_q(ovf_flags)
    );

    assign S_AXI_AWREADY = awready_q;
    assign S_AXI_WREADY = wready_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_ARREADY = arready_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RRESP = rresp_q;
    assign S_AXI_RDATA = rdata_q;
    assign FILTER_HIT = hit_q;
    assign HIT_VALID = hit_valid_q;
    assign FULL_FLAGS = full_flags;
    assign OVF_FLAGS = ovf_flags;

endmodule
